// *** design/ctx_consts.svh ***
// Notes on behaviour
// - Buffers below dedicated plus queue count are active; zero queue means dedicated only.
// - Among active pending buffers the lowest message identifier is sent next.
// - A new priority scan starts on pending-bit updates and on transmission start.
// - Equal identifiers resolve to the lowest buffer number.
// - A successful cancellation sets that buffer's cancel-finished bit.
// - Cancelling a buffer on the bus keeps its pending bit until done.
// - Cancelled frame that still succeeds sets occurred and cancel-finished bits.
// - Cancelled frame that fails is not retried; only cancel-finished is set.
// - A cancel just before start may leave a short gap with no start.
// - Each transmitted frame writes identifier and timestamp to the next event element.
// - The buffer's message marker is copied into the event element.
// - Event FIFO depth is configurable up to 32 elements.
// - While the event FIFO is full no further elements are written.
// - An event arriving while full is dropped and sets the event-lost flag.
// - Fill level reaching the watermark sets the event-watermark flag.
// - Acknowledge write sets get index to value plus one; fill is recomputed.
// - Acknowledge values are not checked; the host writes only valid ones.
`ifndef CTX_CONSTS_SVH
`define CTX_CONSTS_SVH
`define CTX_OFS_TXCFG 12'h000
`define CTX_OFS_ADDREQ 12'h004
`define CTX_OFS_CANCEL 12'h008
`define CTX_OFS_PENDING 12'h00c
`define CTX_OFS_OCCURRED 12'h010
`define CTX_OFS_CANFIN 12'h014
`define CTX_OFS_EVCFG 12'h018
`define CTX_OFS_EVSTAT 12'h01c
`define CTX_OFS_FLAGS 12'h020
`define CTX_OFS_EVACK 12'h024
`define CTX_OFS_RX0ACK 12'h028
`define CTX_OFS_RX1ACK 12'h02c
`define CTX_OFS_RXSTAT 12'h030
`define CTX_BLK_BUFID 5'h01
`define CTX_BLK_BUFMARK 5'h02
`define CTX_TXCFG_DED 5:0
`define CTX_TXCFG_QUE 13:8
`define CTX_TXCFG_MASK 32'h00003f3f
`define CTX_TXCFG_RST 32'h00000000
`define CTX_EVCFG_BASE 15:0
`define CTX_EVCFG_DEPTH 21:16
`define CTX_EVCFG_WM 29:24
`define CTX_EVCFG_MASK 32'h3f3fffff
`define CTX_EVCFG_RST 32'h00000000
`define CTX_FLAG_FULL 0
`define CTX_FLAG_LOST 1
`define CTX_FLAG_WM 2
`define CTX_MAX_DEPTH 6'h20
`define CTX_RESP_OKAY 2'b00
`define CTX_RESP_SLVERR 2'b10
`endif

// *** design/ctx_pkg.sv ***
package ctx_pkg;
   typedef logic [28:0] ctx_id_t;
   typedef logic [4:0] ctx_idx_t;
   typedef logic [31:0] ctx_word_t;
   typedef enum logic {CTX_IDLE, CTX_SEND} ctx_tx_state_t;

   function automatic ctx_idx_t ctx_wrap_inc(input ctx_idx_t i,
                                             input logic [5:0] depth);
      logic [5:0] n;
      n = {1'b0, i} + 6'h01;
      return (n == depth) ? 5'h00 : n[4:0];
   endfunction : ctx_wrap_inc

   function automatic ctx_word_t ctx_merge(input ctx_word_t old,
                                           input ctx_word_t nw,
                                           input logic [3:0] strb);
      ctx_word_t r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : ctx_merge
endpackage : ctx_pkg

// *** design/ctx_prio_scan.sv ***
`timescale 1ns/1ns
`default_nettype none
module ctx_prio_scan (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [31:0] pending,
   input wire ctx_pkg::ctx_id_t id_q,
   output ctx_pkg::ctx_idx_t scan_idx,
   output logic busy,
   output logic done,
   output logic found,
   output ctx_pkg::ctx_idx_t winner
);
   import ctx_pkg::*;
   ctx_id_t best;
   wire take = busy & pending[scan_idx] & (~found | (id_q < best));
   wire last = busy & (scan_idx == 5'h1f);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy <= 1'b0;
         scan_idx <= 5'h00;
         found <= 1'b0;
         best <= '0;
         winner <= 5'h00;
         done <= 1'b0;
      end else begin
         done <= last & ~start;
         if (start) begin
            busy <= 1'b1;
            scan_idx <= 5'h00;
            found <= 1'b0;
         end else if (busy) begin
            scan_idx <= scan_idx + 5'h01;
            busy <= ~last;
            if (take) begin
               best <= id_q;
               winner <= scan_idx;
               found <= 1'b1;
            end
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_LOWEST_KEPT: assert property (busy && !start && pending[scan_idx] |=>
      found && best <= $past(id_q)) else $error("scan lost a lower id");
   AST_TIE_LOW_NUM: assert property (busy && !start && found &&
      pending[scan_idx] && id_q == best |=> winner == $past(winner))
      else $error("equal id replaced lower buffer number");
   AST_SCAN_LEN: assert property (busy && !start |=>
      scan_idx == $past(scan_idx) + 5'h01 &&
      done == ($past(scan_idx) == 5'h1f))
      else $error("scan did not finish in 32 cycles");
endmodule : ctx_prio_scan
`default_nettype wire

// *** design/ctx_evt_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module ctx_evt_fifo (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] depth,
   input wire logic push,
   input wire logic ack_we,
   input wire ctx_pkg::ctx_idx_t ack_val,
   output ctx_pkg::ctx_idx_t put,
   output ctx_pkg::ctx_idx_t get,
   output logic [5:0] fill,
   output logic full,
   output logic push_ok,
   output logic lost
);
   import ctx_pkg::*;
   // The acknowledge value is used as written; a bad value is not caught.
   wire ctx_idx_t next_get = ack_we ? ctx_wrap_inc(ack_val, depth) : get;
   wire ctx_idx_t next_put = ctx_wrap_inc(put, depth);
   assign push_ok = push & ~full & (depth != 6'h00);
   assign lost = push & full;
   assign fill = full ? depth : (put >= get) ? {1'b0, put - get} :
                 {1'b0, put} + depth - {1'b0, get};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         put <= 5'h00;
         get <= 5'h00;
         full <= 1'b0;
      end else begin
         get <= next_get;
         if (push_ok) begin
            put <= next_put;
         end
         if (push_ok && next_put == next_get) begin
            full <= 1'b1;
         end else if (ack_we) begin
            full <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_FULL_HOLD: assert property (full && !ack_we |=> put == $past(put))
      else $error("event written while full");
   AST_ACK_GET: assert property (ack_we |=>
      get == $past(ctx_wrap_inc(ack_val, depth)))
      else $error("get index not acknowledge plus one");
   AST_FILL_MOD: assert property (!full && depth != 6'h00 |->
      fill == ((6'(put) + depth - 6'(get)) % depth))
      else $error("fill level wrong");
endmodule : ctx_evt_fifo
`default_nettype wire

// *** design/ctx_tx_housekeeping.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ctx_consts.svh"
module ctx_tx_housekeeping (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire ctx_pkg::ctx_word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output ctx_pkg::ctx_word_t s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic tx_start,
   output ctx_pkg::ctx_idx_t tx_buffer,
   output ctx_pkg::ctx_id_t tx_id,
   input wire logic tx_done,
   input wire logic tx_ok,
   input wire logic [15:0] tx_timestamp,
   output logic evt_wr,
   output logic [15:0] evt_addr,
   output ctx_pkg::ctx_id_t evt_id,
   output logic [7:0] evt_marker,
   output logic [15:0] evt_timestamp,
   input wire logic [5:0] rx0_put_index,
   input wire logic [5:0] rx1_put_index,
   output logic [5:0] rx0_get_index,
   output logic [5:0] rx1_get_index,
   output logic [5:0] rx0_fill,
   output logic [5:0] rx1_fill
);
   import ctx_pkg::*;

   ctx_word_t txcfg, evcfg, aw_wdata;
   ctx_word_t pending, occurred, canfin, creq;
   ctx_id_t buf_id [32];
   logic [7:0] buf_mark [32];
   logic [2:0] flags;
   logic [11:0] aw_addr;
   logic [3:0] aw_strb;
   logic aw_held, w_held, rescan;
   ctx_tx_state_t state;
   ctx_idx_t cur;
   wire ctx_idx_t scan_idx, scan_win, ev_put, ev_get;
   wire scan_busy, scan_done, scan_found, ev_full, ev_ok, ev_lost;
   wire [5:0] ev_fill;
   wire [31:0] active_mask;

   // Write channel: address and data are taken in either order.
   wire aw_go = s_axi_awvalid & s_axi_awready;
   wire w_go = s_axi_wvalid & s_axi_wready;
   wire wr_go = aw_held & w_held & ~s_axi_bvalid;
   wire next_aw_held = aw_go | (aw_held & ~wr_go);
   wire next_w_held = w_go | (w_held & ~wr_go);
   wire [11:0] wa = {aw_addr[11:2], 2'b00};
   wire ctx_word_t wd1 = ctx_merge(32'h0, aw_wdata, aw_strb);
   wire wr_cfg = wr_go & (wa == `CTX_OFS_TXCFG);
   wire wr_add = wr_go & (wa == `CTX_OFS_ADDREQ);
   wire wr_can = wr_go & (wa == `CTX_OFS_CANCEL);
   wire wr_evcfg = wr_go & (wa == `CTX_OFS_EVCFG);
   wire wr_flags = wr_go & (wa == `CTX_OFS_FLAGS);
   wire wr_evack = wr_go & (wa == `CTX_OFS_EVACK);
   wire wr_rx0 = wr_go & (wa == `CTX_OFS_RX0ACK);
   wire wr_rx1 = wr_go & (wa == `CTX_OFS_RX1ACK);
   wire wr_bid = wr_go & (wa[11:7] == `CTX_BLK_BUFID);
   wire wr_bmk = wr_go & (wa[11:7] == `CTX_BLK_BUFMARK);
   wire ctx_idx_t widx = wa[6:2];
   wire wr_hit = wr_cfg | wr_add | wr_can | wr_evcfg | wr_flags | wr_evack |
                 wr_rx0 | wr_rx1 | wr_bid | wr_bmk;
   wire ctx_word_t bid_m = ctx_merge({3'b000, buf_id[widx]}, aw_wdata,
                                     aw_strb);
   wire ctx_word_t bmk_m = ctx_merge({24'h0, buf_mark[widx]}, aw_wdata,
                                     aw_strb);

   // Read channel decode.
   wire rd_go = s_axi_arvalid & s_axi_arready;
   wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
   wire ctx_idx_t ridx = ra[6:2];
   wire rd_bid = ra[11:7] == `CTX_BLK_BUFID;
   wire rd_bmk = ra[11:7] == `CTX_BLK_BUFMARK;
   wire rd_map = (ra <= `CTX_OFS_RXSTAT) | rd_bid | rd_bmk;
   wire ctx_word_t evstat = {7'h00, ev_full, 3'h0, ev_put, 3'h0, ev_get,
                             2'b00, ev_fill};
   wire ctx_word_t rxstat = {2'b00, rx1_fill, 2'b00, rx1_get_index, 2'b00,
                             rx0_fill, 2'b00, rx0_get_index};
   wire ctx_word_t rd_data =
      rd_bid ? {3'b000, buf_id[ridx]} :
      rd_bmk ? {24'h0, buf_mark[ridx]} :
      (ra == `CTX_OFS_TXCFG) ? txcfg :
      (ra == `CTX_OFS_CANCEL) ? creq :
      (ra == `CTX_OFS_PENDING) ? pending :
      (ra == `CTX_OFS_OCCURRED) ? occurred :
      (ra == `CTX_OFS_CANFIN) ? canfin :
      (ra == `CTX_OFS_EVCFG) ? evcfg :
      (ra == `CTX_OFS_EVSTAT) ? evstat :
      (ra == `CTX_OFS_FLAGS) ? {29'h0, flags} :
      (ra == `CTX_OFS_RXSTAT) ? rxstat : 32'h0;

   // Buffers at and above dedicated plus queue count take no part.
   wire [6:0] nbuf = {1'b0, txcfg[`CTX_TXCFG_DED]} +
                     {1'b0, txcfg[`CTX_TXCFG_QUE]};
   for (genvar i = 0; i < 32; i++) begin : g_act
      assign active_mask[i] = 7'(i) < nbuf;
   end

   // Transmit bookkeeping for the current buffer and for cancels.
   wire busy = state == CTX_SEND;
   wire ctx_word_t cur_mask = busy ? (32'h1 << cur) : 32'h0;
   wire ctx_word_t add_bits = wr_add ? (wd1 & active_mask) : 32'h0;
   wire ctx_word_t can_bits = wr_can ? wd1 : 32'h0;
   wire ctx_word_t cancel_imm = can_bits & pending & ~cur_mask;
   wire ctx_word_t cancel_late = can_bits & pending & cur_mask;
   wire fin = tx_done & busy;
   wire cur_cancelled = (creq[cur] | cancel_late[cur]) & busy;
   wire ctx_word_t done_clr = (fin & (tx_ok | cur_cancelled)) ? cur_mask :
                              32'h0;
   wire ctx_word_t ok_set = (fin & tx_ok) ? cur_mask : 32'h0;
   wire ctx_word_t late_fin = (fin & cur_cancelled) ? cur_mask : 32'h0;
   wire ctx_word_t next_pending = (pending & ~cancel_imm & ~done_clr) |
                                  add_bits;
   wire launch = scan_done & scan_found & ~busy & active_mask[scan_win] &
                 next_pending[scan_win];
   wire push = fin & tx_ok;
   wire [5:0] ev_depth = (evcfg[`CTX_EVCFG_DEPTH] > `CTX_MAX_DEPTH) ?
                         `CTX_MAX_DEPTH : evcfg[`CTX_EVCFG_DEPTH];
   wire wm_hit = ev_ok & (evcfg[`CTX_EVCFG_WM] != 6'h00) &
                 (ev_fill + 6'h01 == evcfg[`CTX_EVCFG_WM]);
   wire [2:0] flag_set = {wm_hit, ev_lost, ev_full};
   wire [2:0] flag_clr = wr_flags ? wd1[2:0] : 3'h0;

   ctx_prio_scan u_scan (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(rescan),
      .pending(pending & active_mask),
      .id_q(buf_id[scan_idx]),
      .scan_idx(scan_idx),
      .busy(scan_busy),
      .done(scan_done),
      .found(scan_found),
      .winner(scan_win)
   );

   ctx_evt_fifo u_evt (
      .aclk(aclk),
      .aresetn(aresetn),
      .depth(ev_depth),
      .push(push),
      .ack_we(wr_evack),
      .ack_val(wd1[4:0]),
      .put(ev_put),
      .get(ev_get),
      .fill(ev_fill),
      .full(ev_full),
      .push_ok(ev_ok),
      .lost(ev_lost)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CTX_RESP_OKAY;
         aw_addr <= 12'h000;
         aw_wdata <= 32'h0;
         aw_strb <= 4'h0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         s_axi_awready <= ~next_aw_held;
         s_axi_wready <= ~next_w_held;
         if (aw_go) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_go) begin
            aw_wdata <= s_axi_wdata;
            aw_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CTX_RESP_OKAY : `CTX_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `CTX_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_map ? rd_data : 32'h0;
         s_axi_rresp <= rd_map ? `CTX_RESP_OKAY : `CTX_RESP_SLVERR;
      end else if (!s_axi_rvalid || s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txcfg <= `CTX_TXCFG_RST;
         evcfg <= `CTX_EVCFG_RST;
         flags <= 3'h0;
         for (int i = 0; i < 32; i++) begin
            buf_id[i] <= '0;
            buf_mark[i] <= 8'h00;
         end
      end else begin
         if (wr_cfg) begin
            txcfg <= ctx_merge(txcfg, aw_wdata, aw_strb) & `CTX_TXCFG_MASK;
         end
         if (wr_evcfg) begin
            evcfg <= ctx_merge(evcfg, aw_wdata, aw_strb) & `CTX_EVCFG_MASK;
         end
         if (wr_bid) begin
            buf_id[widx] <= bid_m[28:0];
         end
         if (wr_bmk) begin
            buf_mark[widx] <= bmk_m[7:0];
         end
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending <= 32'h0;
         occurred <= 32'h0;
         canfin <= 32'h0;
         creq <= 32'h0;
         rescan <= 1'b0;
      end else begin
         pending <= next_pending;
         occurred <= (occurred & ~add_bits) | ok_set;
         canfin <= (canfin & ~add_bits) | cancel_imm | late_fin;
         creq <= (creq | cancel_late) & ~(fin ? cur_mask : 32'h0);
         rescan <= wr_add | wr_can | wr_cfg | fin | launch;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= CTX_IDLE;
         cur <= 5'h00;
         tx_start <= 1'b0;
         tx_buffer <= 5'h00;
         tx_id <= '0;
      end else begin
         tx_start <= launch;
         unique case (state)
            CTX_IDLE: begin
               if (launch) begin
                  state <= CTX_SEND;
                  cur <= scan_win;
                  tx_buffer <= scan_win;
                  tx_id <= buf_id[scan_win];
               end
            end
            CTX_SEND: begin
               if (tx_done) begin
                  state <= CTX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_wr <= 1'b0;
         evt_addr <= 16'h0000;
         evt_id <= '0;
         evt_marker <= 8'h00;
         evt_timestamp <= 16'h0000;
      end else begin
         evt_wr <= ev_ok;
         if (ev_ok) begin
            evt_addr <= evcfg[`CTX_EVCFG_BASE] + {10'h000, ev_put, 1'b0};
            evt_id <= buf_id[cur];
            evt_marker <= buf_mark[cur];
            evt_timestamp <= tx_timestamp;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx0_get_index <= 6'h00;
         rx1_get_index <= 6'h00;
         rx0_fill <= 6'h00;
         rx1_fill <= 6'h00;
      end else begin
         if (wr_rx0) begin
            rx0_get_index <= wd1[5:0] + 6'h01;
         end
         if (wr_rx1) begin
            rx1_get_index <= wd1[5:0] + 6'h01;
         end
         rx0_fill <= rx0_put_index - rx0_get_index;
         rx1_fill <= rx1_put_index - rx1_get_index;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_START_ACTIVE: assert property (tx_start |-> active_mask[tx_buffer])
      else $error("inactive buffer started");
   AST_RESCAN: assert property (launch |-> ##2 scan_busy)
      else $error("no scan after start");
   AST_KEEP_PEND: assert property (busy && creq[cur] |-> pending[cur])
      else $error("pending dropped during transfer");
   AST_CANCEL_FIN: assert property (wr_can && cancel_imm != 32'h0 |=>
      (canfin & $past(cancel_imm)) == $past(cancel_imm) &&
      (pending & $past(cancel_imm)) == 32'h0)
      else $error("cancel not finished");
   AST_OK_CANCEL: assert property (fin && tx_ok && cur_cancelled |=>
      occurred[$past(cur)] && canfin[$past(cur)] && !pending[$past(cur)])
      else $error("cancelled success bits wrong");
   AST_FAIL_CANCEL: assert property (fin && !tx_ok && cur_cancelled &&
      !add_bits[cur] |=> !pending[$past(cur)] && !occurred[$past(cur)] &&
      canfin[$past(cur)]) else $error("cancelled failure bits wrong");
   AST_EVT_ELEM: assert property (ev_ok |=> evt_wr &&
      evt_id == $past(buf_id[cur]) && evt_timestamp == $past(tx_timestamp))
      else $error("event element wrong");
   AST_EVT_MARK: assert property (ev_ok |=>
      evt_marker == $past(buf_mark[cur])) else $error("marker not copied");
   AST_EVT_LOST: assert property (push && ev_full && !wr_flags |=>
      flags[`CTX_FLAG_LOST] && !evt_wr) else $error("lost event not flagged");
   AST_EVT_WM: assert property (wm_hit && !wr_flags |=>
      flags[`CTX_FLAG_WM]) else $error("watermark flag missed");
   COV_CANCEL_LATE: cover property (fin && tx_ok && cur_cancelled);
   COV_CANCEL_FAIL: cover property (fin && !tx_ok && cur_cancelled);
   COV_EVT_LOST: cover property (push && ev_full);
   COV_ACK: cover property (wr_evack ##1 !ev_full);
endmodule : ctx_tx_housekeeping
`default_nettype wire

// *** test/ctx_can_node.sv ***
`timescale 1ns/1ns
`default_nettype none
module ctx_can_node #(parameter int DELAY = 60) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tx_start,
   input wire logic fail,
   output logic tx_done,
   output logic tx_ok,
   output logic [15:0] tx_timestamp
);
   logic [7:0] cnt;
   // Outside the done pulse the outcome toggles, so nobody may lean on it.
   assign tx_ok = tx_done ? !fail : tx_timestamp[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 8'h00;
         tx_done <= 1'b0;
         tx_timestamp <= 16'h0000;
      end else begin
         tx_timestamp <= tx_timestamp + 16'h0001;
         tx_done <= (cnt == 8'h01);
         if (tx_start) begin
            cnt <= 8'(DELAY);
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule : ctx_can_node
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ctx_consts.svh"
module tb;
   import ctx_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, tx_start, tx_done;
   logic tx_ok, evt_wr, fail;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   ctx_word_t s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   ctx_idx_t tx_buffer;
   ctx_id_t tx_id, evt_id;
   logic [15:0] tx_timestamp, evt_addr, evt_timestamp, last_ts;
   logic [7:0] evt_marker;
   logic [5:0] rx0_put_index, rx1_put_index, rx0_get_index;
   logic [5:0] rx1_get_index, rx0_fill, rx1_fill;
   logic [31:0] ev_a[2], ev_i[2], ev_m[2], ev_t[2];
   int err_count = 0, comparisons = 0, n_evt = 0;
   ctx_tx_housekeeping i_dut (.*);
   ctx_can_node i_node (.aclk(aclk), .aresetn(aresetn),
      .tx_start(tx_start), .fail(fail), .tx_done(tx_done), .tx_ok(tx_ok),
      .tx_timestamp(tx_timestamp));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input ctx_word_t d,
                     input logic [1:0] er);
      bit aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1 && !aw) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1 && !w) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : wr
   task automatic rd(input logic [11:0] a, input ctx_word_t e,
                     input logic [1:0] er);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      chk($sformatf("rdata at %h", a), e, s_axi_rdata);
   endtask : rd
   task automatic wstart(input ctx_idx_t b, input ctx_id_t id);
      do @(posedge aclk); while (tx_start !== 1'b1);
      chk("tx_buffer", {27'h0, b}, {27'h0, tx_buffer});
      chk("tx_id", {3'h0, id}, {3'h0, tx_id});
   endtask : wstart
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   always @(posedge aclk) begin
      if (tx_done && tx_ok) last_ts = tx_timestamp;
      if (evt_wr && n_evt < 2) begin
         ev_a[n_evt] = {16'h0, evt_addr};
         ev_i[n_evt] = {3'h0, evt_id};
         ev_m[n_evt] = {24'h0, evt_marker};
         ev_t[n_evt] = {16'h0, evt_timestamp ^ last_ts};
      end
      if (evt_wr) n_evt++;
   end
   initial begin
      repeat (3000) @(posedge aclk);
      err_count++;
      end_sim();
   end
   initial begin
      static logic [28:0] ids[5] = '{29'h5, 29'h3, 29'h3, 29'h9, 29'h1};
      aresetn = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      fail = 1'b0;
      rx0_put_index = 6'h09;
      rx1_put_index = 6'h02;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(`CTX_OFS_PENDING, 32'h0, `CTX_RESP_OKAY);
      rd(12'h7fc, 32'h0, `CTX_RESP_SLVERR);
      wr(12'h7fc, 32'h1, `CTX_RESP_SLVERR);
      wr(`CTX_OFS_PENDING, 32'h1, `CTX_RESP_SLVERR);
      wr(`CTX_OFS_TXCFG, 32'h0202, `CTX_RESP_OKAY);
      for (int n = 0; n < 5; n++) begin
         wr(12'h080 + 12'(4 * n), {3'h0, ids[n]}, `CTX_RESP_OKAY);
         wr(12'h100 + 12'(4 * n), 32'h10 + 32'(n), `CTX_RESP_OKAY);
      end
      wr(`CTX_OFS_EVCFG, 32'h01020100, `CTX_RESP_OKAY);
      wr(`CTX_OFS_ADDREQ, 32'h1f, `CTX_RESP_OKAY);
      rd(`CTX_OFS_PENDING, 32'hf, `CTX_RESP_OKAY);
      $display("setup test done");
      wstart(5'h01, 29'h3);
      wr(`CTX_OFS_CANCEL, 32'h2, `CTX_RESP_OKAY);
      rd(`CTX_OFS_PENDING, 32'hf, `CTX_RESP_OKAY);
      rd(`CTX_OFS_CANCEL, 32'h2, `CTX_RESP_OKAY);
      wstart(5'h02, 29'h3);
      rd(`CTX_OFS_OCCURRED, 32'h2, `CTX_RESP_OKAY);
      rd(`CTX_OFS_CANFIN, 32'h2, `CTX_RESP_OKAY);
      fail <= 1'b1;
      wr(`CTX_OFS_CANCEL, 32'h4, `CTX_RESP_OKAY);
      wstart(5'h00, 29'h5);
      fail <= 1'b0;
      rd(`CTX_OFS_OCCURRED, 32'h2, `CTX_RESP_OKAY);
      rd(`CTX_OFS_CANFIN, 32'h6, `CTX_RESP_OKAY);
      wr(`CTX_OFS_CANCEL, 32'h8, `CTX_RESP_OKAY);
      rd(`CTX_OFS_PENDING, 32'h1, `CTX_RESP_OKAY);
      rd(`CTX_OFS_CANFIN, 32'he, `CTX_RESP_OKAY);
      repeat (80) @(posedge aclk);
      wr(`CTX_OFS_ADDREQ, 32'h8, `CTX_RESP_OKAY);
      wstart(5'h03, 29'h9);
      repeat (80) @(posedge aclk);
      $display("transmit test done");
      chk("event count", 32'h2, 32'(n_evt));
      for (int k = 0; k < 2; k++) begin
         chk("evt_addr", 32'h100 + 32'(2 * k), ev_a[k]);
         chk("evt_id", k ? 32'h5 : 32'h3, ev_i[k]);
         chk("evt_marker", k ? 32'h10 : 32'h11, ev_m[k]);
         chk("evt_timestamp", 32'h0, ev_t[k]);
      end
      rd(`CTX_OFS_FLAGS, 32'h7, `CTX_RESP_OKAY);
      rd(`CTX_OFS_EVSTAT, 32'h01000002, `CTX_RESP_OKAY);
      wr(`CTX_OFS_EVACK, 32'h0, `CTX_RESP_OKAY);
      rd(`CTX_OFS_EVSTAT, 32'h101, `CTX_RESP_OKAY);
      wr(`CTX_OFS_FLAGS, 32'h7, `CTX_RESP_OKAY);
      rd(`CTX_OFS_FLAGS, 32'h0, `CTX_RESP_OKAY);
      $display("event test done");
      wr(`CTX_OFS_RX0ACK, 32'h5, `CTX_RESP_OKAY);
      wr(`CTX_OFS_RX1ACK, 32'h3f, `CTX_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("rx0_get_index", 32'h6, {26'h0, rx0_get_index});
      chk("rx0_fill", 32'h3, {26'h0, rx0_fill});
      chk("rx1_get_index", 32'h0, {26'h0, rx1_get_index});
      chk("rx1_fill", 32'h2, {26'h0, rx1_fill});
      rd(`CTX_OFS_RXSTAT, 32'h02000306, `CTX_RESP_OKAY);
      $display("acknowledge test done");
      end_sim();
   end
endmodule : tb
`default_nettype wire
